// ==== shared/mode_seq_pkg.sv ====
package mode_seq_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ       = 100;          // Core clock rate
	localparam int BOOT_MS       = 100;          // Boot to idle
	localparam int CYCLE_MS      = 100;          // One measurement cycle
	localparam int WAKE_MS       = 100;          // Wake from shutdown
	localparam int BOOT_CYCLES   = BOOT_MS * 1000 * CLK_MHZ;
	localparam int CYCLE_CYCLES  = CYCLE_MS * 1000 * CLK_MHZ;
	localparam int WAKE_CYCLES   = WAKE_MS * 1000 * CLK_MHZ;

	// ************************************************************
	// Widths and reset values
	// ************************************************************
	localparam int DATA_W        = 16;           // Result width
	localparam int NQ            = 4;            // Current, voltage, power, temperature
	localparam logic [7:0] WAKE_READ_VALUE = 8'h01; // Read answer while waking
	localparam logic [7:0] IDLE_CTRL_VALUE = 8'h00; // Control byte once idle
	localparam logic [15:0] MIN_RESET = 16'h7FFF;    // Min tracker start
	localparam logic [15:0] MAX_RESET = 16'h8000;    // Max tracker start

	// ************************************************************
	// Strap levels and pin uses
	// ************************************************************
	typedef enum logic [1:0] {STRAP_LOW, STRAP_HIGH, STRAP_RES} strap_e;
	typedef enum logic [1:0] {PIN_IN, PIN_OUT, PIN_FAN, PIN_GATE} pin_use_e;

endpackage : mode_seq_pkg

// ==== core/measurement_mode_sequencer.sv ====
// Operation
// - strap zero high selects SPI, else I2C
// - strap one is chip select or address
// - straps sampled once at power-up
// - alert pin low on unmasked event
// - I2C alert follows SMBus response protocol
// - threshold exceed sets alert bit, pin
// - running min and max per quantity
// - general pin has four selectable uses
// - boot loads defaults, idle after 100ms
// - idle measures nothing, results kept
// - single shot measures, no accumulation
// - single shot ends: clear, flag, idle, or shutdown if power down set
// - continuous runs back-to-back cycles, accumulating
// - converters run gapless in continuous mode
// - continuous ends at cycle end when host clears it, sets single or sets power down
// - single during continuous: finish, then single
// - power down waits for cycle end, immediate from idle
// - shutdown zeroes results except power, keeps the rest
// - shutdown wakes on select or address
// - waking ignores writes, reads 0x01
// - resume sets both undervoltage flags
`timescale 1ns/1ns
`default_nettype none
module measurement_mode_sequencer
	import mode_seq_pkg::*;
#(
	parameter int BOOT_COUNT  = BOOT_CYCLES,  // Boot delay in clocks
	parameter int CYCLE_COUNT = CYCLE_CYCLES, // Cycle length in clocks
	parameter int WAKE_COUNT  = WAKE_CYCLES   // Wake delay in clocks
) (
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	input  wire logic              strap_zero_high_in,     // Strap zero tied to supply
	input  wire logic [1:0]        strap_one_level_in,     // Strap one level, strap_e
	input  wire logic              select_pin_in,          // Strap one pin as select, async
	input  wire logic              addr_match_in,          // Own address acknowledged, pulse
	input  wire logic              ctrl_wr_in,             // Control write strobe
	input  wire logic              single_measure_request_in,
	input  wire logic              repeat_measure_request_in,
	input  wire logic              power_down_request_in,
	input  wire logic              ara_ack_in,             // Alert response serviced
	input  wire logic              flag_clear_in,          // Clear fresh flag and alert bits
	input  wire logic [NQ*DATA_W-1:0] sample_in,           // Converter results
	input  wire logic [NQ*DATA_W-1:0] thresh_hi_in,        // Upper thresholds
	input  wire logic [NQ-1:0]     alert_mask_in,          // High enables pin
	input  wire logic              error_in,               // Error condition level
	input  wire logic              error_mask_in,          // High enables error on pin
	input  wire logic [1:0]        pin_use_in,             // pin_use_e
	input  wire logic              gp_pin_in,              // General pin level, async
	input  wire logic              gp_drive_in,            // Value for output use
	input  wire logic [DATA_W-1:0] fan_temp_in,            // Fan switch temperature
	output logic                   spi_mode_out,
	output logic [3:0]             i2c_addr_sel_out,       // {strap0,1'b0,strap1 level}
	output logic                   select_active_out,      // Chip select asserted
	output logic                   single_measure_request_out,
	output logic                   repeat_measure_request_out,
	output logic                   power_down_request_out,
	output logic                   fresh_result_flag_out,
	output logic                   analog_undervoltage_flag_out,
	output logic                   digital_undervoltage_flag_out,
	output logic                   converters_run_out,     // Current and power converters
	output logic                   accumulate_out,         // Charge/energy/time step
	output logic                   waking_out,             // Writes dropped, reads 0x01
	output logic [7:0]             read_override_out,
	output logic [NQ-1:0]          alert_bits_out,
	output logic                   alert_oe_out,           // Pull alert low
	output logic                   alert_o_out,
	output logic                   gp_oe_out,
	output logic                   gp_o_out,
	output logic                   gp_level_out,
	output logic [NQ*DATA_W-1:0]   result_out,
	output logic [NQ*DATA_W-1:0]   min_out,
	output logic [NQ*DATA_W-1:0]   max_out
);

	// ************************************************************
	// State and counters
	// ************************************************************
	typedef enum logic [2:0] {BOOT, IDLE, SINGLE, REPEATING, ASLEEP, WAKE} mode_e;
	mode_e mode;                     // Operating mode
	mode_e next_mode;                // Next mode
	logic [31:0] count;              // Cycle and delay timer
	logic        cycle_end;          // Timer expired
	logic        strapped;           // Straps already captured
	logic [1:0]  sel_sync;           // Select synchroniser
	logic [1:0]  gp_sync;            // General pin synchroniser
	logic        sel_prev;           // Last synced select
	logic        sel_fall;           // Select falling edge
	logic        alert_raw;          // Unmasked event pending
	logic        alert_held;         // Alert kept until serviced
	logic [NQ-1:0] exceed;           // Threshold comparison
	logic        is_meas;            // Measurement cycle running
	logic        to_sleep;           // Shutdown entered at this edge
	logic [1:0]  zero_sync;          // Strap zero synchroniser
	logic [1:0]  one_sync_a;         // Strap one level, first stage
	logic [1:0]  one_sync_b;         // Strap one level, second stage

	// Signed greater-than used for limits and trackers
	function automatic logic sgt(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		sgt = $signed(a) > $signed(b);
	endfunction : sgt

	// ************************************************************
	// Decode
	// ************************************************************
	assign is_meas   = (mode == SINGLE) || (mode == REPEATING);
	// Only measurement cycles end; boot and wake run their own counts
	assign cycle_end = is_meas && (count == 32'(CYCLE_COUNT - 1));
	assign to_sleep  = (next_mode == ASLEEP) && (mode != ASLEEP);
	assign sel_fall  = sel_prev & ~sel_sync[1];
	assign select_active_out = spi_mode_out & ~sel_sync[1];

	// Threshold compare per quantity
	genvar q;
	generate
		for (q = 0; q < NQ; q++) begin : g_cmp
			assign exceed[q] = sgt(sample_in[q*DATA_W +: DATA_W], thresh_hi_in[q*DATA_W +: DATA_W]);
		end
	endgenerate

	// Unmasked event drives the pin; error too
	assign alert_raw = |(alert_bits_out & alert_mask_in) | (error_in & error_mask_in);
	assign alert_oe_out = spi_mode_out ? alert_raw : alert_held;
	assign alert_o_out  = 1'b0;
	assign waking_out = (mode == WAKE) || (mode == BOOT);
	assign read_override_out = waking_out ? WAKE_READ_VALUE : IDLE_CTRL_VALUE;
	// Converters run across cycle boundaries in continuous mode
	assign converters_run_out = is_meas;

	// ************************************************************
	// Synchronisers for pins
	// ************************************************************
	// Two flops before use; only the second stage is read
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sel_sync <= 2'b11;
			gp_sync  <= 2'b00;
			sel_prev <= 1'b1;
		end else begin
			sel_sync <= {sel_sync[0], select_pin_in};
			gp_sync  <= {gp_sync[0], gp_pin_in};
			sel_prev <= sel_sync[1];
		end
	end

	// ************************************************************
	// Strap capture
	// ************************************************************
	// Strap pins pass two flops; no reset, so they are settled at release
	always_ff @(posedge clk_in) begin
		zero_sync  <= {zero_sync[0], strap_zero_high_in};
		one_sync_a <= strap_one_level_in;
		one_sync_b <= one_sync_a;
	end

	// Caught once after release; later pin changes cannot swap interface
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			strapped         <= 1'b0;
			spi_mode_out     <= 1'b0;
			i2c_addr_sel_out <= 4'h0;
		end else if (!strapped) begin
			strapped         <= 1'b1;
			spi_mode_out     <= zero_sync[1];
			i2c_addr_sel_out <= {zero_sync[1], 1'b0, one_sync_b};
		end
	end

	// ************************************************************
	// Mode sequencing
	// ************************************************************
	always_comb begin
		next_mode = mode;
		case (mode)
			BOOT:   if (count == 32'(BOOT_COUNT - 1)) next_mode = IDLE;
			IDLE: begin
				// Shutdown first: no cycle to wait for
				if (power_down_request_out)          next_mode = ASLEEP;
				else if (single_measure_request_out) next_mode = SINGLE;
				else if (repeat_measure_request_out) next_mode = REPEATING;
			end
			SINGLE: if (cycle_end) next_mode = power_down_request_out ? ASLEEP : IDLE;
			REPEATING: begin
				if (cycle_end) begin
					if (power_down_request_out)          next_mode = ASLEEP;
					else if (single_measure_request_out) next_mode = SINGLE;
					else if (!repeat_measure_request_out) next_mode = IDLE;
				end
			end
			ASLEEP: begin
				if (spi_mode_out ? sel_fall : addr_match_in) next_mode = WAKE;
			end
			WAKE:   if (count == 32'(WAKE_COUNT - 1)) next_mode = IDLE;
			default: next_mode = BOOT;
		endcase
	end

	// Mode register and shared timer
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			mode  <= BOOT;
			count <= 32'h0;
		end else begin
			mode  <= next_mode;
			count <= (next_mode != mode || cycle_end) ? 32'h0 : count + 32'h1;
		end
	end

	// ************************************************************
	// Control and status bits
	// ************************************************************
	// Host writes ignored while waking; hardware clears apply only when no write is taken
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			single_measure_request_out <= 1'b0;
			repeat_measure_request_out <= 1'b0;
			power_down_request_out     <= 1'b0;
		end else if (ctrl_wr_in && !waking_out) begin
			single_measure_request_out <= single_measure_request_in;
			repeat_measure_request_out <= repeat_measure_request_in;
			power_down_request_out     <= power_down_request_in;
		end else begin
			if (mode == SINGLE && cycle_end)
				single_measure_request_out <= 1'b0;
			if (mode == REPEATING && cycle_end && single_measure_request_out)
				repeat_measure_request_out <= 1'b0;
			if (is_meas && cycle_end && power_down_request_out) begin
				single_measure_request_out <= 1'b0;
				repeat_measure_request_out <= 1'b0;
			end
			if (mode == WAKE && next_mode == IDLE)
				power_down_request_out <= 1'b0;
		end
	end

	// Status flags: set beats clear
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			fresh_result_flag_out         <= 1'b0;
			analog_undervoltage_flag_out  <= 1'b0;
			digital_undervoltage_flag_out <= 1'b0;
			alert_bits_out                <= '0;
			alert_held                    <= 1'b0;
		end else begin
			if (mode == SINGLE && cycle_end)
				fresh_result_flag_out <= 1'b1;
			else if (flag_clear_in)
				fresh_result_flag_out <= 1'b0;
			if (mode == WAKE && next_mode == IDLE) begin
				analog_undervoltage_flag_out  <= 1'b1;
				digital_undervoltage_flag_out <= 1'b1;
			end else if (flag_clear_in) begin
				analog_undervoltage_flag_out  <= 1'b0;
				digital_undervoltage_flag_out <= 1'b0;
			end
			if (is_meas && cycle_end)
				alert_bits_out <= exceed | (flag_clear_in ? '0 : alert_bits_out);
			else if (flag_clear_in)
				alert_bits_out <= '0;
			// Pin released once host's response read picks us
			if (alert_raw)
				alert_held <= 1'b1;
			else if (ara_ack_in)
				alert_held <= 1'b0;
		end
	end

	// ************************************************************
	// Results and trackers
	// ************************************************************
	// Accumulation only in continuous mode, optionally gated by pin
	assign accumulate_out = (mode == REPEATING) && cycle_end &&
		(pin_use_e'(pin_use_in) != PIN_GATE || gp_sync[1]);

	generate
		for (q = 0; q < NQ; q++) begin : g_res
			logic [DATA_W-1:0] s;          // This quantity's sample
			logic [DATA_W-1:0] res_q;      // Result register
			logic [DATA_W-1:0] min_q;      // Minimum tracker
			logic [DATA_W-1:0] max_q;      // Maximum tracker
			logic              zero_q;     // Cleared on entering shutdown
			assign s      = sample_in[q*DATA_W +: DATA_W];
			// Power (index 2) kept; trackers untouched
			assign zero_q = to_sleep && (q != 2);
			// One register set per quantity, so each slice has one driver
			assign result_out[q*DATA_W +: DATA_W] = res_q;
			assign min_out[q*DATA_W +: DATA_W]    = min_q;
			assign max_out[q*DATA_W +: DATA_W]    = max_q;
			always_ff @(posedge clk_in) begin
				if (!rstn_in) begin
					res_q <= '0;
					min_q <= MIN_RESET;
					max_q <= MAX_RESET;
				end else if (cycle_end) begin
					// A cycle that ends in shutdown still feeds the trackers
					res_q <= zero_q ? '0 : s;
					if (sgt(min_q, s))
						min_q <= s;
					if (sgt(s, max_q))
						max_q <= s;
				end else if (zero_q) begin
					res_q <= '0;
				end
			end
		end
	endgenerate
	// Idle keeps results since only cycle ends and shutdown entry write them

	// ************************************************************
	// General-purpose pin
	// ************************************************************
	assign gp_level_out = gp_sync[1];
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			gp_oe_out <= 1'b0;
			gp_o_out  <= 1'b0;
		end else begin
			gp_o_out <= 1'b0;
			case (pin_use_e'(pin_use_in))
				PIN_OUT: gp_oe_out <= ~gp_drive_in;
				PIN_FAN: gp_oe_out <= sgt(result_out[3*DATA_W +: DATA_W], fan_temp_in);
				default: gp_oe_out <= 1'b0;
			endcase
		end
	end

endmodule : measurement_mode_sequencer
`default_nettype wire

// ==== tb/mode_seq_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********************************
// Mode sequencer checker
// ********************************
module mode_seq_props
	import mode_seq_pkg::*;
#(
	parameter int CYCLE_COUNT = CYCLE_CYCLES // Cycle length in clocks
) (
	input wire logic          clk_in,
	input wire logic          rstn_in,
	input wire logic          strap_zero_high_in,
	input wire logic          select_pin_in,
	input wire logic          ctrl_wr_in,
	input wire logic [NQ-1:0] alert_mask_in,
	input wire logic          error_in,
	input wire logic          error_mask_in,
	input wire logic          spi_mode_out,
	input wire logic          single_measure_request_out,
	input wire logic          repeat_measure_request_out,
	input wire logic          power_down_request_out,
	input wire logic          fresh_result_flag_out,
	input wire logic          analog_undervoltage_flag_out,
	input wire logic          digital_undervoltage_flag_out,
	input wire logic          converters_run_out,
	input wire logic          waking_out,
	input wire logic [7:0]    read_override_out,
	input wire logic [NQ-1:0] alert_bits_out,
	input wire logic          alert_oe_out
);
	// Worst wait: finish a running cycle, then run one more
	localparam int LIM = 2 * CYCLE_COUNT + 8;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Continuous with nothing pending
	sequence s_repeat_measure_request_steady;
		repeat_measure_request_out && !single_measure_request_out && !power_down_request_out;
	endsequence
	// Single shot closed out
	sequence s_single_end;
		!single_measure_request_out && fresh_result_flag_out;
	endsequence
	a_strap_capture: assert property ($rose(rstn_in) |=> spi_mode_out == $past(strap_zero_high_in))
		else $error("port mode differs from strap");
	a_strap_held: assert property (!$rose(rstn_in) |=> $stable(spi_mode_out))
		else $error("port mode moved after power-up");
	a_alert_pull: assert property (spi_mode_out && (|(alert_bits_out & alert_mask_in) ||
		(error_in && error_mask_in)) |-> alert_oe_out) else $error("alert pin not pulled");
	a_single_end: assert property ($rose(single_measure_request_out) |-> ##[1:LIM] s_single_end)
		else $error("single shot never closed");
	a_repeat_measure_request_stays: assert property (s_repeat_measure_request_steady ##0 !ctrl_wr_in |=> repeat_measure_request_out)
		else $error("continuous left on its own");
	a_repeat_measure_request_gapless: assert property (s_repeat_measure_request_steady ##0 $past(repeat_measure_request_out) |-> converters_run_out)
		else $error("converters paused in continuous");
	a_wake_read: assert property (read_override_out == (waking_out ? WAKE_READ_VALUE : IDLE_CTRL_VALUE))
		else $error("read answer wrong for wake state");
	a_wake_flags: assert property ($fell(power_down_request_out) |-> ##[0:2]
		(analog_undervoltage_flag_out && digital_undervoltage_flag_out)) else $error("undervoltage flags not set");
	a_wake_select: assert property (spi_mode_out && power_down_request_out && !waking_out &&
		!converters_run_out && $fell(select_pin_in) |-> ##[1:5] waking_out) else $error("select did not wake");
endmodule : mode_seq_props
bind measurement_mode_sequencer mode_seq_props #(.CYCLE_COUNT(CYCLE_COUNT)) props (.*);
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********************************
// Host side of the control port
// ********************************
module host_model (
	input  wire logic clk_in,
	output logic      ctrl_wr_out,
	output logic      single_out,
	output logic      repeat_out,
	output logic      power_down_out,
	output logic      select_n_out
);
	// Quiet port; select rests at its pull-up
	initial begin
		ctrl_wr_out = 1'b0;
		{single_out, repeat_out, power_down_out} = 3'h0;
		select_n_out = 1'b1;
	end
	// One write replaces all three bits
	task automatic write_ctrl(input logic s, input logic r, input logic p);
		@(posedge clk_in);
		#1;
		{single_out, repeat_out, power_down_out} = {s, r, p};
		ctrl_wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		ctrl_wr_out = 1'b0;
		// Released bits show junk, never the old value
		{single_out, repeat_out, power_down_out} = ~{s, r, p};
	endtask : write_ctrl
	// Short select pulse, as a frame start would give
	task automatic spi_select();
		@(posedge clk_in);
		#1;
		select_n_out = 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		select_n_out = 1'b1;
	endtask : spi_select
endmodule : host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********************************
// Mode sequencer bench
// ********************************
module tb_top
	import mode_seq_pkg::*;
;
	localparam int N = 20; // Short boot, cycle, wake
	localparam logic [63:0] S1 = 64'h0040_0300_0200_0100; // T P V I
	localparam logic [63:0] S2 = 64'h0030_0280_01F0_00F0; // All lower
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [63:0] sample = S1;
	logic        flag_clr = 1'b0;
	logic        err = 1'b0;
	logic        emask = 1'b1;
	logic [63:0] thr = 64'h7FFF_7FFF_7FFF_0080; // Only the current limit is reachable
	logic [3:0]  amask = 4'h1;
	logic [1:0]  pin_use = 2'h0;
	logic        gp_pin = 1'b1;
	logic        gp_drv = 1'b0;
	logic        conv, gp_oe, gp_lvl;
	logic [3:0]  asel;
	int          n_acc0 = 0;
	logic        h_wr, h_s, h_r, h_p, h_cs_n;
	logic        spi, s_o, r_o, p_o, fresh, auv, duv, acc, wake, aoe;
	logic [7:0]  rdo;
	logic [3:0]  abits;
	logic [63:0] res, mn, mx;
	int          n_fail = 0;
	int          total_checks = 0;
	int          n_acc = 0;
	always #5 clk_in = ~clk_in;
	// Count accumulation steps where the pulse is settled
	always @(negedge clk_in) if (acc) n_acc++;
	host_model host (.clk_in(clk_in), .ctrl_wr_out(h_wr), .single_out(h_s), .repeat_out(h_r),
		.power_down_out(h_p), .select_n_out(h_cs_n));
	measurement_mode_sequencer #(.BOOT_COUNT(N), .CYCLE_COUNT(N), .WAKE_COUNT(N)) dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .strap_zero_high_in(1'b1), .strap_one_level_in(2'h0),
		.select_pin_in(h_cs_n), .addr_match_in(1'b0), .ctrl_wr_in(h_wr), .single_measure_request_in(h_s),
		.repeat_measure_request_in(h_r), .power_down_request_in(h_p), .ara_ack_in(1'b0),
		.flag_clear_in(flag_clr), .sample_in(sample), .thresh_hi_in(thr),
		.alert_mask_in(amask), .error_in(err), .error_mask_in(emask), .pin_use_in(pin_use), .gp_pin_in(gp_pin),
		.gp_drive_in(gp_drv), .fan_temp_in(16'h0000), .spi_mode_out(spi), .i2c_addr_sel_out(asel),
		.select_active_out(), .single_measure_request_out(s_o), .repeat_measure_request_out(r_o),
		.power_down_request_out(p_o), .fresh_result_flag_out(fresh), .analog_undervoltage_flag_out(auv),
		.digital_undervoltage_flag_out(duv), .converters_run_out(conv), .accumulate_out(acc), .waking_out(wake),
		.read_override_out(rdo), .alert_bits_out(abits), .alert_oe_out(aoe), .alert_o_out(), .gp_oe_out(gp_oe),
		.gp_o_out(), .gp_level_out(gp_lvl), .result_out(res), .min_out(mn), .max_out(mx));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	// Four-state compare, zero-extended
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	// Hang guard, well past the expected run
	initial begin
		#50000;
		n_fail++;
		wrap_up();
	end
	initial begin
		tick(10);
		rstn_in = 1'b1;
		host.write_ctrl(1'b1, 1'b0, 1'b0);
		tick(2);
		chk("boot write", 1'b0, s_o);
		for (int i = 0; i < 40 && wake !== 1'b0; i++) tick(1);
		chk("booted", 1'b0, wake);
		chk("spi mode", 1'b1, spi);
		chk("addr straps", 4'h8, asel);
		chk("min default", {4{MIN_RESET}}, mn);
		chk("max default", {4{MAX_RESET}}, mx);
		err = 1'b1;
		tick(1);
		chk("error alert", 1'b1, aoe);
		emask = 1'b0;
		tick(1);
		chk("masked error", 1'b0, aoe);
		err = 1'b0;
		pin_use = 2'h1;
		tick(1);
		chk("gp drive low", 1'b1, gp_oe);
		gp_drv = 1'b1;
		tick(1);
		chk("gp released", 1'b0, gp_oe);
		gp_pin = 1'b0;
		tick(3);
		chk("gp input", 1'b0, gp_lvl);
		gp_pin = 1'b1;
		tick(30);
		chk("idle result", 64'h0, res);
		host.write_ctrl(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 60 && fresh !== 1'b1; i++) tick(1);
		chk("single result", S1, res);
		chk("single cleared", 1'b0, s_o);
		chk("single accum", 0, n_acc);
		chk("min first", S1, mn);
		chk("alert bits", 4'h1, abits);
		chk("alert pin", 1'b1, aoe);
		amask = 4'h0;
		tick(1);
		chk("masked alert", 1'b0, aoe);
		amask = 4'h1;
		pin_use = 2'h2;
		tick(1);
		chk("fan on", 1'b1, gp_oe);
		// Gate use from here on; pin high lets accumulation run
		pin_use = 2'h3;
		flag_clr = 1'b1;
		sample = S2;
		tick(1);
		flag_clr = 1'b0;
		host.write_ctrl(1'b0, 1'b1, 1'b0);
		tick(3 * N + 10);
		chk("repeat_measure_request held", 1'b1, r_o);
		chk("repeat_measure_request run", 1'b1, conv);
		chk("repeat_measure_request accum", 1'b1, n_acc >= 2);
		chk("min track", S2, mn);
		chk("max track", S1, mx);
		host.write_ctrl(1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 3 * N + 10 && s_o !== 1'b0; i++) tick(1);
		chk("repeat_measure_request cleared", 1'b0, r_o);
		chk("single after repeat_measure_request", 1'b1, fresh);
		// Gate closed: the next cycle end must not accumulate
		gp_pin = 1'b0;
		n_acc0 = n_acc;
		host.write_ctrl(1'b0, 1'b1, 1'b0);
		tick(4);
		host.write_ctrl(1'b0, 1'b1, 1'b1);
		tick(2);
		chk("cycle kept", 1'b1, r_o);
		for (int i = 0; i < 2 * N + 8 && r_o !== 1'b0; i++) tick(1);
		tick(4);
		chk("shutdown result", {16'h0000, S2[47:32], 32'h0}, res);
		chk("shutdown min", S2, mn);
		chk("shutdown max", S1, mx);
		chk("gated accum", n_acc0, n_acc);
		host.spi_select();
		chk("waking", 1'b1, wake);
		chk("wake read", WAKE_READ_VALUE, rdo);
		host.write_ctrl(1'b1, 1'b0, 1'b0);
		tick(1);
		chk("wake write", 1'b0, s_o);
		for (int i = 0; i < 2 * N + 8 && wake !== 1'b0; i++) tick(1);
		tick(2);
		chk("idle read", IDLE_CTRL_VALUE, rdo);
		chk("analog uv", 1'b1, auv);
		chk("digital uv", 1'b1, duv);
		host.write_ctrl(1'b0, 1'b0, 1'b1);
		tick(1);
		chk("idle shutdown", 1'b1, p_o);
		host.spi_select();
		chk("idle shutdown wake", 1'b1, wake);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
